// ==== sfpv_engine.sv ====
// Program/verify command engine: address counter, write latches, flash array and timers.
// Assumes the serial link shifter runs on the programmer's clock and hands over one
// command event at a time, with at least the command-to-data gap between events.
`timescale 1ns/1ps
module sfpv_engine
  import sfpv_pkg::*;
#(
  parameter int PROG_AW = 14,
  parameter int INT_PROG_CYCLES = INT_PROG_CYC,
  parameter int INT_CFG_CYCLES = INT_CFG_CYC,
  parameter int ROW_ERASE_CYCLES = ROW_ERASE_CYC,
  parameter logic [13:0] DEVICE_ID_WORD = 14'h1234 // Arbitrary identity value
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_i,
  output logic prog_data_pin_o,
  output logic prog_data_pin_oe,
  input wire logic code_protect_setting,
  output logic write_busy,
  output logic [15:0] address_counter
);

  localparam int PROG_WORDS = 1 << PROG_AW;

  // ==========================================================
  // Storage
  logic [13:0] prog_mem [PROG_WORDS];
  logic [13:0] cfg_mem [CFG_WORDS];
  logic [13:0] latch [LATCHES];
  logic [LATCHES-1:0] latch_valid;

  // ==========================================================
  // Link side and crossing
  logic ev_toggle;
  logic [5:0] ev_cmd;
  logic [13:0] ev_word;
  logic [13:0] rd_word;
  logic ev_sync1;
  logic ev_sync2;
  logic ev_seen;
  logic ev_fire;

  sfpv_link u_link (
    .prog_clk(prog_clock_pin),
    .rst(rst),
    .prog_data_pin_i(prog_data_pin_i),
    .prog_data_pin_o(prog_data_pin_o),
    .prog_data_pin_oe(prog_data_pin_oe),
    .ev_toggle(ev_toggle),
    .ev_cmd(ev_cmd),
    .ev_word(ev_word),
    .rd_word(rd_word)
  );

  // Toggle synchroniser; the command and word are held stable by the link meanwhile
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_sync1 <= 1'b0;
      ev_sync2 <= 1'b0;
      ev_seen <= 1'b0;
    end else begin
      ev_sync1 <= ev_toggle;
      ev_sync2 <= ev_sync1;
      ev_seen <= ev_sync2;
    end
  end

  assign ev_fire = ev_sync2 ^ ev_seen;

  // ==========================================================
  // Decode of the current address
  logic in_cfg;
  logic in_user_id_erase;
  logic [3:0] cfg_idx;
  logic [4:0] latch_idx;
  logic [PROG_AW-1:0] prog_idx;
  logic [10:0] row_sel;

  assign in_cfg = address_counter >= CFG_BASE;
  assign in_user_id_erase = in_cfg && address_counter <= ROW_ERASE_ID_LAST;
  assign cfg_idx = address_counter[3:0];
  assign latch_idx = address_counter[ROW_LSB-1:0];
  assign prog_idx = address_counter[PROG_AW-1:0];
  assign row_sel = address_counter[ADDR_W-1:ROW_LSB];

  // ==========================================================
  // Operation state and timer
  sfpv_op_e op;
  logic [TIMER_W-1:0] timer;
  logic [15:0] op_addr;
  logic op_to_cfg;
  logic op_erase_ids;
  logic commit;
  logic erase_done;

  assign write_busy = op != OP_IDLE;
  assign commit = (op == OP_INT_WRITE && timer == '0)
                || (op == OP_EXT_WRITE && ev_fire && ev_cmd == CMD_END_EXT);
  assign erase_done = op == OP_ROW_ERASE && timer == '0;

  // Start, time and finish the write and erase operations
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op <= OP_IDLE;
      timer <= '0;
      op_addr <= ADDR_ZERO;
      op_to_cfg <= 1'b0;
      op_erase_ids <= 1'b0;
    end else if (op == OP_IDLE) begin
      if (ev_fire && ev_cmd == CMD_BEGIN_INT) begin
        op <= OP_INT_WRITE;
        op_addr <= address_counter;
        op_to_cfg <= in_cfg;
        timer <= in_cfg ? TIMER_W'(INT_CFG_CYCLES - 1) : TIMER_W'(INT_PROG_CYCLES - 1);
      end else if (ev_fire && ev_cmd == CMD_BEGIN_EXT) begin
        op <= OP_EXT_WRITE; // Ended only by the programmer's end command
        op_addr <= address_counter;
        op_to_cfg <= in_cfg;
      end else if (ev_fire && ev_cmd == CMD_ROW_ERASE) begin
        // Protected program rows and other configuration words are left alone
        if (in_user_id_erase || (!in_cfg && !code_protect_setting)) begin
          op <= OP_ROW_ERASE;
          op_addr <= address_counter;
          op_erase_ids <= in_user_id_erase;
          timer <= TIMER_W'(ROW_ERASE_CYCLES - 1);
        end
      end
    end else if (commit || erase_done) begin
      op <= OP_IDLE;
    end else if (timer != '0) begin
      timer <= timer - TIMER_W'(1);
    end
  end

  // ==========================================================
  // Address counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      address_counter <= ADDR_ZERO;
    end else if (ev_fire) begin
      if (ev_cmd == CMD_LOAD_CFG) begin
        address_counter <= CFG_BASE;
      end else if (ev_cmd == CMD_INC_ADDR) begin
        address_counter <= address_counter + ADDR_ONE;
      end else if (ev_cmd == CMD_RESET_ADDR) begin
        address_counter <= ADDR_ZERO;
      end
    end
  end

  // ==========================================================
  // Write latches; a later load into the same slot simply overwrites it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_valid <= '0;
    end else begin
      // A load that lands in the commit cycle survives the clear
      if (commit) begin
        latch_valid <= '0;
      end
      if (ev_fire && ev_cmd == CMD_LOAD_DATA) begin
        latch_valid[latch_idx] <= 1'b1;
      end else if (ev_fire && ev_cmd == CMD_LOAD_CFG) begin
        latch_valid[0] <= 1'b1;
      end
    end
  end

  // Latch data words; no reset, since the valid bits say which ones count
  always_ff @(posedge sys_clk) begin
    if (ev_fire && ev_cmd == CMD_LOAD_DATA) begin
      latch[latch_idx] <= ev_word;
    end else if (ev_fire && ev_cmd == CMD_LOAD_CFG) begin
      latch[ROW_LSB'(0)] <= ev_word;
    end
  end

  // ==========================================================
  // Program memory array: writes only clear bits, erase sets the row
  always_ff @(posedge sys_clk) begin
    if (commit && !op_to_cfg) begin
      for (int i = 0; i < LATCHES; i++) begin
        if (latch_valid[i]) begin
          // Row from the begin address, word from the latch slot
          prog_mem[PROG_AW'({op_addr[ADDR_W-1:ROW_LSB], 5'(i)})] <=
            prog_mem[PROG_AW'({op_addr[ADDR_W-1:ROW_LSB], 5'(i)})] & latch[i];
        end
      end
    end else if (erase_done && !op_erase_ids) begin
      for (int i = 0; i < LATCHES; i++) begin
        prog_mem[PROG_AW'({op_addr[ADDR_W-1:ROW_LSB], 5'(i)})] <= ERASED_WORD;
      end
    end
  end

  // ==========================================================
  // Configuration space: only internally timed writes reach it, one word at a time
  logic cfg_write_ok;

  assign cfg_write_ok = commit && op_to_cfg && op == OP_INT_WRITE
                      && latch_valid[op_addr[ROW_LSB-1:0]]
                      && op_addr != DEV_ID_ADDR;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_mem[i] <= ERASED_WORD;
      end
    end else if (cfg_write_ok) begin
      cfg_mem[op_addr[3:0]] <= cfg_mem[op_addr[3:0]] & latch[op_addr[ROW_LSB-1:0]];
    end else if (erase_done && op_erase_ids) begin
      for (int i = 0; i <= int'(USER_ID_LAST[3:0]); i++) begin
        cfg_mem[i] <= ERASED_WORD;
      end
    end
  end

  // ==========================================================
  // Read word for the link; settles well inside the command-to-data gap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_word <= ZERO_WORD;
    end else if (ev_fire && ev_cmd == CMD_READ_DATA) begin
      if (in_cfg) begin
        // Configuration space reads ignore code protection
        rd_word <= (address_counter == DEV_ID_ADDR) ? DEVICE_ID_WORD : cfg_mem[cfg_idx];
      end else if (code_protect_setting) begin
        rd_word <= ZERO_WORD;
      end else begin
        rd_word <= prog_mem[prog_idx];
      end
    end
  end

  // Unused upper row bits are harmless for small arrays; folded into row_unused, which nothing reads
  logic row_unused;

  assign row_unused = ^row_sel;

endmodule

// ==== sfpv_pkg.sv ====
// Constants, command codes and link states for the serial flash program/verify engine.
// Assumes a 10 MHz system clock; all timing counts derive from that period.
package sfpv_pkg;

  // Link framing
  localparam int CMD_BITS = 6;
  localparam int FRAME_CLKS = 16;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 16;

  // Command codes, sent least significant bit first
  localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
  localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
  localparam logic [5:0] CMD_READ_DATA = 6'h04;
  localparam logic [5:0] CMD_INC_ADDR = 6'h06;
  localparam logic [5:0] CMD_RESET_ADDR = 6'h16;
  localparam logic [5:0] CMD_BEGIN_INT = 6'h08;
  localparam logic [5:0] CMD_BEGIN_EXT = 6'h18;
  localparam logic [5:0] CMD_END_EXT = 6'h0A;
  localparam logic [5:0] CMD_BULK_ERASE = 6'h09;
  localparam logic [5:0] CMD_ROW_ERASE = 6'h11;

  // Address map
  localparam logic [15:0] CFG_BASE = 16'h8000;
  localparam logic [15:0] USER_ID_LAST = 16'h8003;
  localparam logic [15:0] ROW_ERASE_ID_LAST = 16'h8008;
  localparam logic [15:0] DEV_ID_ADDR = 16'h8006;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  localparam int ROW_LSB = 5;
  localparam int LATCHES = 32;
  localparam int CFG_WORDS = 16;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [13:0] ZERO_WORD = 14'h0000;

  // Timing, figures as printed and derived cycle counts (longest times round down)
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int INT_PROG_TIME_NS = 2500000;
  localparam int INT_CFG_TIME_NS = 5000000;
  localparam int ROW_ERASE_TIME_NS = 2500000;
  localparam int INT_PROG_CYC = INT_PROG_TIME_NS / SYS_CLK_PERIOD_NS;
  localparam int INT_CFG_CYC = INT_CFG_TIME_NS / SYS_CLK_PERIOD_NS;
  localparam int ROW_ERASE_CYC = ROW_ERASE_TIME_NS / SYS_CLK_PERIOD_NS;
  localparam int TIMER_W = 17;

  // Link-side frame states
  typedef enum logic [1:0] {
    LK_CMD,
    LK_LOAD,
    LK_READ
  } sfpv_link_e;

  // Engine operation in progress
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_INT_WRITE,
    OP_EXT_WRITE,
    OP_ROW_ERASE
  } sfpv_op_e;

endpackage

// ==== sfpv_link.sv ====
// Serial link shifter for the program/verify engine, clocked by the programmer's clock.
// Assumes the programmer clock stands still between frames and that the read word
// from the system domain settles during the command-to-data gap.
`timescale 1ns/1ps
module sfpv_link
  import sfpv_pkg::*;
(
  input wire logic prog_clk,
  input wire logic rst,
  input wire logic prog_data_pin_i,
  output logic prog_data_pin_o,
  output logic prog_data_pin_oe,
  output logic ev_toggle,
  output logic [5:0] ev_cmd,
  output logic [13:0] ev_word,
  input wire logic [13:0] rd_word
);

  sfpv_link_e state;
  logic [2:0] bit_cnt;
  logic [3:0] frame_cnt;
  logic [5:0] cmd_sr;
  logic [15:0] data_sr;
  logic [5:0] next_cmd;
  logic [15:0] next_frame;

  assign next_cmd = {prog_data_pin_i, cmd_sr[5:1]};
  assign next_frame = {prog_data_pin_i, data_sr[15:1]};

  // ==========================================================
  // Falling edge: sample input bits, walk the frames
  always_ff @(negedge prog_clk or posedge rst) begin
    if (rst) begin
      state <= LK_CMD;
      bit_cnt <= 3'h0;
      frame_cnt <= 4'h0;
      cmd_sr <= 6'h00;
      data_sr <= 16'h0000;
      ev_toggle <= 1'b0;
      ev_cmd <= 6'h00;
      ev_word <= 14'h0000;
      prog_data_pin_oe <= 1'b0;
    end else begin
      unique case (state)
        LK_CMD: begin
          cmd_sr <= next_cmd;
          if (bit_cnt == 3'(CMD_BITS - 1)) begin
            bit_cnt <= 3'h0;
            frame_cnt <= 4'h0;
            ev_cmd <= next_cmd;
            if (next_cmd == CMD_LOAD_CFG || next_cmd == CMD_LOAD_DATA) begin
              state <= LK_LOAD; // Event waits for the data frame
            end else if (next_cmd == CMD_READ_DATA) begin
              state <= LK_READ;
              ev_toggle <= ~ev_toggle; // Early, so the word is ready by the frame
            end else begin
              ev_toggle <= ~ev_toggle;
            end
          end else begin
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        LK_LOAD: begin
          data_sr <= next_frame;
          frame_cnt <= frame_cnt + 4'h1;
          if (frame_cnt == 4'(FRAME_CLKS - 1)) begin
            ev_word <= next_frame[WORD_W:1];
            ev_toggle <= ~ev_toggle;
            state <= LK_CMD;
          end
        end
        LK_READ: begin
          frame_cnt <= frame_cnt + 4'h1;
          if (frame_cnt == 4'h0) begin
            prog_data_pin_oe <= 1'b1;
          end
          if (frame_cnt == 4'(FRAME_CLKS - 1)) begin
            prog_data_pin_oe <= 1'b0;
            state <= LK_CMD;
          end
        end
        default: state <= LK_CMD;
      endcase
    end
  end

  // ==========================================================
  // Rising edge: data bits from the second rising edge, start and stop read as zero
  always_ff @(posedge prog_clk or posedge rst) begin
    if (rst) begin
      prog_data_pin_o <= 1'b0;
    end else if (state == LK_READ && frame_cnt >= 4'h1 && frame_cnt <= 4'(WORD_W)) begin
      prog_data_pin_o <= rd_word[frame_cnt - 4'h1];
    end else begin
      prog_data_pin_o <= 1'b0;
    end
  end

endmodule

// ==== sfpv_monitor.sv ====
// Checker for the program/verify engine, watching only the engine's top-level ports.
// Assumes the programmer clock idles low and stands still between frames.
`timescale 1ns/1ps
module sfpv_monitor
  import sfpv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_o,
  input wire logic prog_data_pin_oe,
  input wire logic code_protect_setting,
  input wire logic write_busy,
  input wire logic [15:0] address_counter
);
  // ==========================================
  // Read frame on the link
  // Fifteen falling edges with the driver on, counting the one where it rises, then released
  sequence s_drive15;
    prog_data_pin_oe[*8] ##1 prog_data_pin_oe[*7];
  endsequence
  property p_oe_len;
    @(negedge prog_clock_pin) disable iff (rst) $rose(prog_data_pin_oe) |-> s_drive15 ##1 !prog_data_pin_oe;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("Data pin driver window wrong");
  property p_first_bit;
    @(negedge prog_clock_pin) disable iff (rst) $rose(prog_data_pin_oe) |-> !$past(prog_data_pin_o);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("Data shifted before second rise");
  property p_stop_bit;
    @(negedge prog_clock_pin) disable iff (rst) $rose(prog_data_pin_oe) |-> ##14 !prog_data_pin_o;
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("Stop bit not low");
  // Protection is checked per bit, since a leak could hit any position
  property p_cp_read;
    @(negedge prog_clock_pin) disable iff (rst)
      prog_data_pin_oe && code_protect_setting && address_counter < CFG_BASE |-> !prog_data_pin_o;
  endproperty
  a_cp_read: assert property (p_cp_read) else $error("Protected word leaked");
  // ==========================================
  // System side
  property p_busy_hold;
    @(posedge sys_clk) disable iff (rst) $rose(write_busy) |-> write_busy[*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Busy dropped early");
  property p_addr_step;
    @(posedge sys_clk) disable iff (rst) address_counter != $past(address_counter) |->
      address_counter == $past(address_counter) + ADDR_ONE || address_counter == ADDR_ZERO ||
      address_counter == CFG_BASE;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("Address jumped");
  property p_addr_read;
    @(posedge sys_clk) disable iff (rst) prog_data_pin_oe && $past(prog_data_pin_oe) |-> $stable(address_counter);
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("Address moved during read");
  property p_addr_busy;
    @(posedge sys_clk) disable iff (rst) write_busy && $past(write_busy) |-> $stable(address_counter);
  endproperty
  a_addr_busy: assert property (p_addr_busy) else $error("Address moved during write");
endmodule

bind sfpv_engine sfpv_monitor u_mon (
  .sys_clk(sys_clk),
  .rst(rst),
  .prog_clock_pin(prog_clock_pin),
  .prog_data_pin_o(prog_data_pin_o),
  .prog_data_pin_oe(prog_data_pin_oe),
  .code_protect_setting(code_protect_setting),
  .write_busy(write_busy),
  .address_counter(address_counter)
);

// ==== sfpv_programmer.sv ====
// Behavioural programmer: drives the link clock and data, reads words back.
// Assumes the bench resolves the data wire from this model and the device driver.
`timescale 1ns/1ps
module sfpv_programmer
  import sfpv_pkg::*;
(
  output logic prog_clk,
  output logic drv,
  input wire logic pin
);
  localparam int HALF_NS = 24;
  localparam int GAP_NS = 1200;
  // Clock idles low; it only moves inside frames
  initial begin
    prog_clk = 1'b0;
    drv = 1'b0;
  end
  // ==========================================
  // Link primitives
  // Data changes on the rising edge, so it never races the sampling fall
  task automatic clk_bit(input logic b);
    #HALF_NS prog_clk = 1'b1;
    drv = b;
    #HALF_NS prog_clk = 1'b0;
  endtask
  // Every frame ends with an idle gap so the next event is well spaced
  task automatic send_cmd(input logic [5:0] code);
    for (int i = 0; i < CMD_BITS; i++) begin
      clk_bit(code[i]);
    end
    #GAP_NS;
  endtask
  task automatic send_word(input logic [13:0] w);
    logic [15:0] f;
    f = {1'b0, w, 1'b0};
    for (int i = 0; i < FRAME_CLKS; i++) begin
      clk_bit(f[i]);
    end
    #GAP_NS;
  endtask
  // Released line toggles so a floating pin never reads as a steady value
  task automatic read_word(output logic [13:0] w);
    w = ZERO_WORD;
    for (int i = 1; i <= FRAME_CLKS; i++) begin
      drv = ~drv;
      #HALF_NS prog_clk = 1'b1;
      #(HALF_NS - 4);
      if (i >= 2 && i <= 15) w[i-2] = pin;
      #4 prog_clk = 1'b0;
    end
    #GAP_NS;
  endtask
endmodule

// ==== test_serial_flash_program_verify.sv ====
// Self-checking bench for the program/verify engine with a behavioural programmer.
// Assumes the shortened write and erase counts set on the engine instance below.
`timescale 1ns/1ps
module test_serial_flash_program_verify
  import sfpv_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic code_protect_setting = 1'b0;
  logic prog_clk, prog_drv, pin_o, pin_oe, write_busy, pin;
  logic [15:0] address_counter;
  int bad_count = 0;
  int checks = 0;
  localparam logic [13:0] WORD_A = 14'h2A5C;
  localparam logic [13:0] WORD_B = 14'h1FF3;
  localparam logic [13:0] WORD_C = 14'h0155;

  // Clock and resolved data wire: the device wins while it drives
  always #50 sys_clk = ~sys_clk;
  assign pin = pin_oe ? pin_o : prog_drv;

  sfpv_engine #(.INT_PROG_CYCLES(20), .INT_CFG_CYCLES(40), .ROW_ERASE_CYCLES(20)) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .prog_clock_pin(prog_clk),
    .prog_data_pin_i(pin),
    .prog_data_pin_o(pin_o),
    .prog_data_pin_oe(pin_oe),
    .code_protect_setting(code_protect_setting),
    .write_busy(write_busy),
    .address_counter(address_counter)
  );
  sfpv_programmer prog (.prog_clk(prog_clk), .drv(prog_drv), .pin(pin));

  // ==========================================
  // Checking and reporting
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Busy must be up, then drop within a bounded wait
  task automatic wait_done(input string what);
    int n;
    n = 0;
    chk(what, 16'h0001, {15'h0000, write_busy});
    while (write_busy !== 1'b0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100) begin
      bad_count++;
      $display("CHECK FAILED %s expected 0 seen 1", what);
      final_report();
    end
  endtask
  task automatic load(input logic [13:0] w);
    prog.send_cmd(CMD_LOAD_DATA);
    prog.send_word(w);
  endtask
  task automatic rd(input string what, input logic [13:0] exp);
    logic [13:0] w;
    prog.send_cmd(CMD_READ_DATA);
    prog.read_word(w);
    chk(what, {2'b00, exp}, {2'b00, w});
  endtask
  task automatic ext_write();
    prog.send_cmd(CMD_BEGIN_EXT);
    repeat (13) @(negedge sys_clk);
    prog.send_cmd(CMD_END_EXT);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_program_int();
    prog.send_cmd(CMD_ROW_ERASE);
    wait_done("row erase busy");
    rd("erased word", ERASED_WORD);
    load(WORD_A);
    rd("word before begin", ERASED_WORD);
    prog.send_cmd(CMD_BEGIN_INT);
    wait_done("internal write busy");
    rd("written word", WORD_A);
    load(WORD_B);
    prog.send_cmd(CMD_BEGIN_INT);
    wait_done("second write busy");
    rd("no pre-erase", WORD_A & WORD_B);
    $display("Test program_int done");
  endtask
  task automatic t_protect();
    @(negedge sys_clk) code_protect_setting = 1'b1;
    rd("protected read", ZERO_WORD);
    prog.send_cmd(CMD_ROW_ERASE);
    chk("protected erase busy", 16'h0000, {15'h0000, write_busy});
    @(negedge sys_clk) code_protect_setting = 1'b0;
    rd("erase ignored", WORD_A & WORD_B);
    $display("Test protect done");
  endtask
  task automatic t_config();
    prog.send_cmd(CMD_LOAD_CFG);
    prog.send_word(WORD_C);
    chk("config address", CFG_BASE, address_counter);
    rd("user id blank", ERASED_WORD);
    ext_write();
    rd("ext config ignored", ERASED_WORD);
    prog.send_cmd(CMD_LOAD_CFG);
    prog.send_word(WORD_C);
    prog.send_cmd(CMD_BEGIN_INT);
    wait_done("config write busy");
    rd("config written", WORD_C);
    @(negedge sys_clk) code_protect_setting = 1'b1;
    prog.send_cmd(CMD_ROW_ERASE);
    wait_done("id erase busy");
    @(negedge sys_clk) code_protect_setting = 1'b0;
    rd("id erased", ERASED_WORD);
    $display("Test config done");
  endtask
  task automatic t_overwrite();
    prog.send_cmd(CMD_RESET_ADDR);
    chk("reset address", ADDR_ZERO, address_counter);
    prog.send_cmd(CMD_ROW_ERASE);
    wait_done("erase busy");
    load(WORD_A);
    for (int i = 0; i < LATCHES; i++) begin
      prog.send_cmd(CMD_INC_ADDR);
    end
    chk("after 32 steps", 16'h0020, address_counter);
    load(WORD_C);
    prog.send_cmd(CMD_RESET_ADDR);
    ext_write();
    rd("overwritten latch", WORD_C);
    $display("Test overwrite done");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_program_int();
    t_protect();
    t_config();
    t_overwrite();
    final_report();
  end
endmodule
